// File: core/ncs_nand_host.sv
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
// What this block does
// - page read before first cache read
// - cache read before cache read end
// - random cache read: 00h-30h, then 00h-31h
// - status in cache read, 00h resumes
// - copy-back data may be checked first
// - ascending pages, limited partial programs
// - program: 80h, five addresses, data
// - last cache-program page uses 10h
// - copy-back program: 85h, address, data, 10h
// - copy-back only within same block parity
// - while busy only status commands
module ncs_nand_host
    import ncs_pkg::*;
#(
    parameter int PG_BITS = 6,
    parameter int PP_LIMIT = 4
) (
    input logic mclk,
    input logic nrst,
    input logic clk_en,
    input logic [2:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output ncs_pins_s nand_pins,
    input logic [7:0] dq_in,
    input logic rb_n
);
    ncs_state_e st;
    ncs_state_e nst;
    ncs_state_e post_adr;
    ncs_state_e post_c1;
    ncs_op_e cur;
    ncs_op_e wop;
    ncs_seq_s sq;
    logic act, ph, bdone, rd_got, err, xrd, tz;
    logic g_allow, g_base, g_cact, g_rdses, g_lded, g_cpy;
    logic [7:0] rbyte, xbyte, nstat, bbyte;
    logic [1:0] bk;
    logic [2:0] ai;
    logic [23:0] row;
    logic [15:0] col;
    logic [TMR_W-1:0] tval;

    // ********************************
    // register bus decode
    // ********************************
    wire sel_op = avs_address == REG_OP;
    wire sel_row = avs_address == REG_ROW;
    wire sel_col = avs_address == REG_COL;
    wire sel_data = avs_address == REG_DATA;
    wire sel_stat = avs_address == REG_STAT;
    wire rq = avs_read || avs_write;
    wire commit = rq && !avs_waitrequest;
    wire eng_idle = st == S_IDLE && !act;
    assign wop = ncs_op_e'(avs_writedata[3:0]);
    wire op_req = avs_write && sel_op;
    wire op_ok = g_allow && (rb_n || wop == OP_STATUS);
    wire accept_op = commit && op_req && op_ok;
    wire refuse = commit && op_req && !op_ok;
    wire din_go = commit && avs_write && sel_data;
    wire dout_go = avs_read && sel_data && eng_idle && !rd_got && avs_waitrequest;
    wire need_idle = op_req || (avs_write && sel_data);
    wire rdy = (avs_read && sel_data) ? rd_got : (need_idle ? eng_idle : 1'h1);
    wire answer = rq && avs_waitrequest && rdy;
    // nand status byte carries cache-ready and array-idle bits
    wire [31:0] stat_w = {16'h0000, nstat, 2'h0, g_lded, g_cact, g_rdses, err, rb_n, !eng_idle};
    wire [31:0] rmux = sel_stat ? stat_w :
                       sel_row ? {8'h00, row} :
                       sel_col ? {16'h0000, col} :
                       sel_data ? {24'h000000, rbyte} :
                       sel_op ? {28'h0000000, cur} : 32'h00000000;

    // waitrequest idles high; drops for exactly the answering cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            avs_waitrequest <= 1'h1;
            avs_readdata <= 32'h00000000;
        end else if (clk_en) begin
            avs_waitrequest <= !answer;
            if (answer) begin
                avs_readdata <= rmux;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            row <= 24'h000000;
            col <= 16'h0000;
            err <= 1'h0;
            xbyte <= 8'h00;
            xrd <= 1'h0;
            rd_got <= 1'h0;
            nstat <= 8'h00;
            cur <= OP_NONE;
        end else if (clk_en) begin
            if (commit && avs_write && sel_row) begin
                row <= avs_writedata[23:0];
            end
            if (commit && avs_write && sel_col) begin
                col <= avs_writedata[15:0];
            end
            // a refusal in the clearing cycle keeps the flag
            if (refuse) begin
                err <= 1'h1;
            end else if (commit && avs_write && sel_stat && avs_writedata[ST_ERR]) begin
                err <= 1'h0;
            end
            if (din_go) begin
                xbyte <= avs_writedata[7:0];
                xrd <= 1'h0;
            end else if (dout_go) begin
                xrd <= 1'h1;
            end
            if (st == S_XFER && bdone && xrd) begin
                rd_got <= 1'h1;
            end else if (commit) begin
                rd_got <= 1'h0;
            end
            if (st == S_RD1 && bdone) begin
                nstat <= rbyte;
            end
            if (accept_op) begin
                cur <= wop;
            end
        end
    end

    // ********************************
    // command sequences
    // ********************************
    always_comb begin
        sq = '{c1: C_STATUS, na: 3'h0, c2v: 1'h0, c2: C_RD_SETUP, wrb: 1'h0, rd1: 1'h0};
        case (cur)
            OP_PAGE_READ: begin
                sq.c1 = C_RD_SETUP;
                sq.na = NA_FULL;
                sq.c2v = 1'h1;
                sq.c2 = C_RD_CONF;
                sq.wrb = 1'h1;
            end
            OP_CACHE_SEQ: begin
                sq.c1 = C_CACHE_RD;
                sq.wrb = 1'h1;
            end
            OP_CACHE_RAND: begin
                sq.c1 = C_RD_SETUP;
                sq.na = NA_FULL;
                sq.c2v = 1'h1;
                sq.c2 = C_CACHE_RD;
                sq.wrb = 1'h1;
            end
            OP_CACHE_END: begin
                sq.c1 = C_CACHE_END;
                sq.wrb = 1'h1;
            end
            OP_COPY_READ: begin
                sq.c1 = C_RD_SETUP;
                sq.na = NA_FULL;
                sq.c2v = 1'h1;
                sq.c2 = C_COPY_RD;
                sq.wrb = 1'h1;
            end
            OP_COL_OUT: begin
                sq.c1 = C_COL_OUT;
                sq.na = NA_COL;
                sq.c2v = 1'h1;
                sq.c2 = C_COL_OUT_CONF;
            end
            OP_PROG_SETUP: begin
                sq.c1 = C_PROG_SETUP;
                sq.na = NA_FULL;
            end
            OP_COL_IN: begin
                sq.c1 = C_COL_IN;
                sq.na = NA_COL;
            end
            OP_COPY_PROG: begin
                sq.c1 = C_COL_IN;
                sq.na = NA_FULL;
            end
            OP_PROG_CONF: begin
                sq.c1 = C_PROG_CONF;
                sq.wrb = 1'h1;
            end
            OP_CACHE_PROG: begin
                sq.c1 = C_CACHE_PROG;
                sq.wrb = 1'h1;
            end
            OP_STATUS: begin
                sq.rd1 = 1'h1;
                sq.c2v = g_rdses;
            end
            default: begin
            end
        endcase
    end

    assign post_adr = sq.rd1 ? S_RD1 : (sq.c2v ? S_C2 : (sq.wrb ? S_SETTLE : S_IDLE));
    assign post_c1 = sq.na != 3'h0 ? S_ADDR : post_adr;
    wire last_adr = ai == sq.na - 3'h1;

    always_comb begin
        nst = st;
        case (st)
            S_IDLE: begin
                if (accept_op) begin
                    nst = S_C1;
                end else if (din_go || dout_go) begin
                    nst = S_XFER;
                end
            end
            S_C1: nst = bdone ? post_c1 : st;
            S_ADDR: nst = (bdone && last_adr) ? post_adr : st;
            S_RD1: nst = bdone ? (sq.c2v ? S_C2 : S_IDLE) : st;
            S_C2: nst = bdone ? (sq.wrb ? S_SETTLE : S_IDLE) : st;
            S_SETTLE: nst = tz ? S_WAIT_RB : st;
            S_WAIT_RB: nst = rb_n ? S_IDLE : st;
            S_XFER: nst = bdone ? S_IDLE : st;
            default: nst = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st <= S_IDLE;
            ai <= 3'h0;
        end else if (clk_en) begin
            st <= nst;
            ai <= (st == S_ADDR) ? (bdone ? ai + 3'h1 : ai) : 3'h0;
        end
    end

    // ********************************
    // pin cycle engine
    // ********************************
    wire bus_st = st == S_C1 || st == S_ADDR || st == S_RD1 || st == S_C2 || st == S_XFER;
    wire bstart = bus_st && !act && !bdone;
    wire to_hi = act && tz && !ph;
    wire enter_settle = nst == S_SETTLE && st != S_SETTLE;
    wire tload = bstart || to_hi || enter_settle;
    // random cache reads send column zero; the target ignores it anyway
    wire [15:0] col_use = cur == OP_CACHE_RAND ? 16'h0000 : col;
    wire [39:0] adr_sh = {row, col_use} >> {ai, 3'h0};

    assign tval = bstart ? TMR_W'(STB_LO_CYC - 1) : (to_hi ? TMR_W'(STB_HI_CYC - 1) : TMR_W'(SETTLE_CYC - 1));
    assign bk = st == S_ADDR ? K_ADR :
                (st == S_RD1 || (st == S_XFER && xrd)) ? K_DOUT :
                st == S_XFER ? K_DIN : K_CMD;
    assign bbyte = st == S_ADDR ? adr_sh[7:0] :
                   st == S_C2 ? sq.c2 :
                   st == S_XFER ? xbyte : sq.c1;

    ncs_timer #(
        .W(TMR_W)
    ) u_timer (
        .mclk(mclk),
        .nrst(nrst),
        .clk_en(clk_en),
        .load(tload),
        .val(tval),
        .zero(tz)
    );

    ncs_guard #(
        .PG_BITS(PG_BITS),
        .PP_LIMIT(PP_LIMIT)
    ) u_guard (
        .mclk(mclk),
        .nrst(nrst),
        .clk_en(clk_en),
        .op(wop),
        .go(accept_op),
        .din(din_go),
        .row(row),
        .allow(g_allow),
        .base(g_base),
        .cact(g_cact),
        .rdses(g_rdses),
        .lded(g_lded),
        .cpy(g_cpy)
    );

    // strobe low phase, then high phase; latches happen on the rising strobe
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            nand_pins <= PIN_RST;
            act <= 1'h0;
            ph <= 1'h0;
            bdone <= 1'h0;
            rbyte <= 8'h00;
        end else if (clk_en) begin
            bdone <= 1'h0;
            nand_pins.ce_n <= 1'h0;
            nand_pins.wp_n <= 1'h1;
            if (bstart) begin
                act <= 1'h1;
                ph <= 1'h0;
                nand_pins.cle <= bk == K_CMD;
                nand_pins.ale <= bk == K_ADR;
                nand_pins.dq_oe <= bk != K_DOUT;
                nand_pins.dq_out <= bbyte;
                nand_pins.we_n <= bk == K_DOUT;
                nand_pins.re_n <= bk != K_DOUT;
            end else if (to_hi) begin
                ph <= 1'h1;
                nand_pins.we_n <= 1'h1;
                nand_pins.re_n <= 1'h1;
                if (!nand_pins.re_n) begin
                    rbyte <= dq_in;
                end
            end else if (act && tz) begin
                act <= 1'h0;
                bdone <= 1'h1;
                nand_pins.cle <= 1'h0;
                nand_pins.ale <= 1'h0;
                nand_pins.dq_oe <= 1'h0;
            end
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    cmd_latch_a: assert property (nand_pins.cle |-> !nand_pins.ale && !nand_pins.ce_n && nand_pins.re_n)
        else $error("command latch with wrong control levels");
    busy_only_status_a: assert property (accept_op && !rb_n |-> wop == OP_STATUS)
        else $error("non-status command taken while busy");
    cache_after_read_a: assert property (accept_op && (wop == OP_CACHE_SEQ || wop == OP_CACHE_RAND) |-> g_base)
        else $error("cache read without preceding page read");
    end_after_cache_a: assert property (accept_op && wop == OP_CACHE_END |-> g_cact)
        else $error("cache end without cache read");
    confirm_data_a: assert property (accept_op && wop == OP_PROG_CONF |-> g_lded || g_cpy)
        else $error("program confirm without data");
    ready_release_a: assert property (clk_en && st == S_WAIT_RB && rb_n |=> st == S_IDLE && !act)
        else $error("ready not followed by idle");
    status_resume_a: assert property (clk_en && st == S_RD1 && bdone && g_rdses |=> st == S_C2 ##0 sq.c2 == C_RD_SETUP)
        else $error("status read in read session not resumed");
    cache_col_zero_a: assert property (bstart && st == S_ADDR && cur == OP_CACHE_RAND && ai < 3'h2 |=> nand_pins.dq_out == 8'h00)
        else $error("random cache read column not zero");
    refuse_flag_a: assert property (clk_en && refuse |=> err && $stable(st))
        else $error("refused order did not raise error");

    page_read_c: cover property (st == S_C2 && cur == OP_PAGE_READ ##1 st == S_SETTLE);
    cache_prog_c: cover property (accept_op && wop == OP_CACHE_PROG);
    status_resume_c: cover property (st == S_RD1 && g_rdses ##[1:20] st == S_C2);
    refuse_c: cover property (refuse);
endmodule // ncs_nand_host

// File: core/ncs_pkg.sv
package ncs_pkg;
    // ********************************
    // timing
    // ********************************
    localparam int CLK_NS = 20;
    localparam int STB_LO_NS = 40;
    localparam int STB_HI_NS = 40;
    localparam int SETTLE_NS = 100;
    localparam int STB_LO_CYC = (STB_LO_NS + CLK_NS - 1) / CLK_NS;
    localparam int STB_HI_CYC = (STB_HI_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 8;
    // ********************************
    // flash command bytes
    // ********************************
    localparam logic [7:0] C_RD_SETUP = 8'h00;
    localparam logic [7:0] C_RD_CONF = 8'h30;
    localparam logic [7:0] C_CACHE_RD = 8'h31;
    localparam logic [7:0] C_CACHE_END = 8'h3F;
    localparam logic [7:0] C_COPY_RD = 8'h35;
    localparam logic [7:0] C_COL_OUT = 8'h05;
    localparam logic [7:0] C_COL_OUT_CONF = 8'hE0;
    localparam logic [7:0] C_PROG_SETUP = 8'h80;
    localparam logic [7:0] C_COL_IN = 8'h85;
    localparam logic [7:0] C_PROG_CONF = 8'h10;
    localparam logic [7:0] C_CACHE_PROG = 8'h15;
    localparam logic [7:0] C_STATUS = 8'h70;
    localparam logic [2:0] NA_COL = 3'h2;
    localparam logic [2:0] NA_FULL = 3'h5;
    // ********************************
    // register map, word addresses
    // ********************************
    localparam logic [2:0] REG_OP = 3'h0;
    localparam logic [2:0] REG_ROW = 3'h1;
    localparam logic [2:0] REG_COL = 3'h2;
    localparam logic [2:0] REG_DATA = 3'h3;
    localparam logic [2:0] REG_STAT = 3'h4;
    localparam int ST_ERR = 2;
    localparam logic [1:0] K_CMD = 2'h0;
    localparam logic [1:0] K_ADR = 2'h1;
    localparam logic [1:0] K_DIN = 2'h2;
    localparam logic [1:0] K_DOUT = 2'h3;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0, OP_PAGE_READ = 4'h1, OP_CACHE_SEQ = 4'h2, OP_CACHE_RAND = 4'h3,
        OP_CACHE_END = 4'h4, OP_COPY_READ = 4'h5, OP_COL_OUT = 4'h6, OP_PROG_SETUP = 4'h7,
        OP_COL_IN = 4'h8, OP_PROG_CONF = 4'h9, OP_CACHE_PROG = 4'hA, OP_COPY_PROG = 4'hB,
        OP_STATUS = 4'hC
    } ncs_op_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_C1 = 3'h1, S_ADDR = 3'h2, S_RD1 = 3'h3,
        S_C2 = 3'h4, S_SETTLE = 3'h5, S_WAIT_RB = 3'h6, S_XFER = 3'h7
    } ncs_state_e;

    typedef struct packed {
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic re_n;
        logic wp_n;
        logic dq_oe;
        logic [7:0] dq_out;
    } ncs_pins_s;

    typedef struct packed {
        logic [7:0] c1;
        logic [2:0] na;
        logic c2v;
        logic [7:0] c2;
        logic wrb;
        logic rd1;
    } ncs_seq_s;

    localparam ncs_pins_s PIN_RST = '{cle: 1'h0, ale: 1'h0, ce_n: 1'h1, we_n: 1'h1,
        re_n: 1'h1, wp_n: 1'h0, dq_oe: 1'h0, dq_out: 8'h00};
endpackage

// File: core/ncs_timer.sv
`timescale 1ns/100ps
module ncs_timer #(
    parameter int W = 8
) (
    input logic mclk,
    input logic nrst,
    input logic clk_en,
    input logic load,
    input logic [W-1:0] val,
    output logic zero
);
    logic [W-1:0] cnt;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt <= '0;
        end else if (clk_en) begin
            if (load) begin
                cnt <= val;
            end else if (cnt != '0) begin
                cnt <= cnt - 1'h1;
            end
        end
    end

    assign zero = cnt == '0;
endmodule // ncs_timer

// File: core/ncs_guard.sv
`timescale 1ns/100ps
module ncs_guard
    import ncs_pkg::*;
#(
    parameter int PG_BITS = 6,
    parameter int PP_LIMIT = 4
) (
    input logic mclk,
    input logic nrst,
    input logic clk_en,
    input ncs_op_e op,
    input logic go,
    input logic din,
    input logic [23:0] row,
    output logic allow,
    output logic base,
    output logic cact,
    output logic rdses,
    output logic lded,
    output logic cpy
);
    localparam int PW = $clog2(PP_LIMIT + 1);
    logic popen, cbv, spar, cpend, lrv;
    logic [23:0] lrow;
    logic [PW-1:0] pcnt;

    wire [23:0] pmask = (24'h1 << PG_BITS) - 24'h1;
    wire same_blk = (row >> PG_BITS) == (lrow >> PG_BITS);
    wire [23:0] pg = row & pmask;
    wire [23:0] lpg = lrow & pmask;
    wire seq_ok = !lrv || !same_blk || pg > lpg || (pg == lpg && pcnt < PW'(PP_LIMIT));
    wire par_ok = row[PG_BITS] == spar;

    always_comb begin
        case (op)
            OP_PAGE_READ, OP_COPY_READ: allow = !cpend;
            OP_CACHE_SEQ, OP_CACHE_RAND: allow = base;
            OP_CACHE_END: allow = cact;
            OP_COL_OUT: allow = rdses;
            OP_PROG_SETUP: allow = seq_ok;
            OP_COL_IN: allow = popen;
            OP_PROG_CONF: allow = popen && (lded || cpy);
            OP_CACHE_PROG: allow = popen && lded && !cpy;
            OP_COPY_PROG: allow = cbv && par_ok && seq_ok && !cpend;
            OP_STATUS: allow = 1'h1;
            default: allow = 1'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            {base, cact, rdses, lded, cpy, popen, cbv, spar, cpend, lrv} <= '0;
            lrow <= 24'h000000;
            pcnt <= '0;
        end else if (clk_en) begin
            if (din && popen) begin
                lded <= 1'h1;
            end
            if (go) begin
                case (op)
                    OP_PAGE_READ: begin
                        // a plain page read opens a read session but never arms copy-back
                        {base, cact, rdses, cbv} <= 4'hA;
                    end
                    OP_CACHE_SEQ, OP_CACHE_RAND: begin
                        {cact, rdses, cbv} <= 3'h6;
                    end
                    OP_CACHE_END: begin
                        {base, cact} <= 2'h0;
                    end
                    OP_COPY_READ: begin
                        {base, cact, rdses, cbv} <= 4'h3;
                        spar <= row[PG_BITS];
                    end
                    OP_PROG_SETUP, OP_COPY_PROG: begin
                        {base, cact, rdses, cbv, lded} <= 5'h00;
                        popen <= 1'h1;
                        cpy <= op == OP_COPY_PROG;
                        lrv <= 1'h1;
                        lrow <= row;
                        pcnt <= (lrv && row == lrow) ? pcnt + 1'h1 : PW'(1);
                    end
                    OP_PROG_CONF: begin
                        {popen, lded, cpy, cpend} <= 4'h0;
                    end
                    OP_CACHE_PROG: begin
                        {popen, lded} <= 2'h0;
                        cpend <= 1'h1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // ncs_guard

// File: tb/ncs_flash_model.sv
`timescale 1ns/100ps
module ncs_flash_model
    import ncs_pkg::*;
(
    input wire logic mclk,
    input wire ncs_pins_s pins,
    output logic [7:0] dq_in,
    output logic rb_n
);
    logic we_q = 1'h1;
    logic re_q = 1'h1;
    logic smd = 1'h0;
    logic ld = 1'h0;
    logic [7:0] col = 8'h00;
    logic [7:0] last = 8'h00;
    logic [23:0] row = 24'h000000;
    logic [23:0] arr = 24'h000000;
    logic [23:0] cache = 24'h000000;
    logic [2:0] na = 3'h0;
    int busy = 0;
    int prog = 0;
    wire we_up = pins.we_n && !we_q && !pins.ce_n && pins.re_n;
    // an undriven bus gives the inverse of the last byte, so a missing enable shows
    wire [7:0] d = pins.dq_oe ? pins.dq_out : ~last;
    wire [7:0] rd = smd ? {pins.wp_n, rb_n, rb_n && prog == 0, 5'h00} : cache[7:0] ^ col;
    assign rb_n = busy == 0;
    // released bus shows the inverse of the last byte, so stale data cannot pass
    assign dq_in = pins.re_n ? ~last : rd;
    always @(posedge mclk) begin
        we_q <= pins.we_n;
        re_q <= pins.re_n;
        if (busy > 0) busy <= busy - 1;
        if (prog > 0) prog <= prog - 1;
        if (pins.re_n && !re_q) begin
            last <= rd;
            if (!smd) col <= col + 8'h01;
        end
        if (we_up && pins.cle && !pins.ale) begin
            na <= 3'h0;
            smd <= d == C_STATUS;
            case (d)
                C_RD_CONF, C_COPY_RD: begin
                    arr <= row;
                    cache <= row;
                    col <= 8'h00;
                    ld <= d == C_COPY_RD;
                    busy <= 20;
                end
                C_CACHE_RD, C_CACHE_END: begin
                    cache <= arr;
                    if (d == C_CACHE_RD) arr <= na == 3'h5 ? row : arr + 24'h000001;
                    col <= 8'h00;
                    busy <= 10;
                end
                C_PROG_CONF, C_CACHE_PROG: begin
                    // a new page waits until the pending array program is done
                    if (ld) busy <= (d == C_PROG_CONF ? 30 : 8) + prog;
                    if (ld) prog <= d == C_PROG_CONF ? 0 : prog + 38;
                    ld <= 1'h0;
                end
                default: ;
            endcase
        end else if (we_up && pins.ale) begin
            na <= na + 3'h1;
            if (na == 3'h0) col <= d;
            else if (na >= 3'h2) row[8*(int'(na)-2) +: 8] <= d;
        end else if (we_up) begin
            ld <= 1'h1;
            col <= col + 8'h01;
        end
    end
endmodule // ncs_flash_model

// File: tb/ncs_nand_host_tb_top.sv
`timescale 1ns/100ps
module ncs_nand_host_tb_top;
    import ncs_pkg::*;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    ncs_pins_s nand_pins;
    logic [7:0] dq_in;
    logic rb_n;
    logic [31:0] seed = 32'hB775;
    logic [31:0] q;
    logic [23:0] r;
    logic [7:0] c;
    int error_cnt = 0;
    int n_checks = 0;
    ncs_nand_host i_dut (.mclk(mclk), .nrst(nrst), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .nand_pins(nand_pins),
        .dq_in(dq_in), .rb_n(rb_n));
    ncs_flash_model i_flash (.mclk(mclk), .pins(nand_pins), .dq_in(dq_in), .rb_n(rb_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 300);
        q = avs_readdata;
        if (avs_waitrequest !== 1'b0) begin
            chk("waitrequest", 32'h0, 32'h1);
            complete_run();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    // refused orders only raise the err flag, so every order is judged by it
    task automatic run(input logic [3:0] code, input logic err);
        int n;
        bus(1'b1, REG_OP, {28'h0, code});
        n = 0;
        do begin
            bus(1'b0, REG_STAT, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        chk("idle", 32'h0, 32'(q[0]));
        chk("err", 32'(err), 32'(q[ST_ERR]));
        if (q[ST_ERR] === 1'b1) bus(1'b1, REG_STAT, 32'h4);
    endtask
    task automatic rd(input logic [23:0] row, input logic [7:0] col);
        bus(1'b0, REG_DATA, 32'h0);
        chk("data", 32'(row[7:0] ^ col), 32'(q[7:0]));
    endtask
    initial begin
        forever #10 mclk = ~mclk;
    end
    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("ce_n", 32'h0, 32'(nand_pins.ce_n));
        chk("wp_n", 32'h1, 32'(nand_pins.wp_n));
        bus(1'b0, 3'h7, 32'h0);
        chk("unmapped", 32'h0, q);
        run(OP_CACHE_SEQ, 1'b1);
        run(OP_CACHE_END, 1'b1);
        run(OP_PROG_CONF, 1'b1);
        repeat (2) begin
            seed = xs(seed);
            r = {8'h00, seed[15:0]};
            c = seed[23:16];
            bus(1'b1, REG_ROW, {8'h00, r});
            run(OP_PAGE_READ, 1'b0);
            for (int i = 0; i < 3; i++) begin
                run(i < 2 ? OP_CACHE_SEQ : OP_CACHE_END, 1'b0);
                for (int j = 0; j <= int'(seed[24+2*i +: 2]); j++) rd(r + 24'(i), 8'(j));
            end
            bus(1'b1, REG_COL, {24'h0, c});
            run(OP_COL_OUT, 1'b0);
            rd(r + 24'h2, c);
            run(OP_STATUS, 1'b0);
            chk("status", 32'hE0, 32'(q[15:8]));
            rd(r + 24'h2, c + 8'h01);
            bus(1'b1, REG_ROW, {8'h00, r});
            run(OP_PAGE_READ, 1'b0);
            bus(1'b1, REG_ROW, {8'h00, r ^ 24'h00A5C0});
            run(OP_CACHE_RAND, 1'b0);
            rd(r, 8'h00);
            run(OP_CACHE_END, 1'b0);
            rd(r ^ 24'h00A5C0, 8'h00);
        end
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, REG_ROW, 32'h200 + 32'(p));
            run(OP_PROG_SETUP, 1'b0);
            seed = xs(seed);
            bus(1'b1, REG_DATA, {24'h0, seed[7:0]});
            bus(1'b1, REG_COL, 32'h5);
            run(OP_COL_IN, 1'b0);
            bus(1'b1, REG_DATA, {24'h0, seed[15:8]});
            run(p == 0 ? OP_CACHE_PROG : OP_PROG_CONF, 1'b0);
        end
        run(OP_STATUS, 1'b0);
        chk("status", 32'hE0, 32'(q[15:8]));
        bus(1'b1, REG_ROW, 32'h300);
        run(OP_COPY_READ, 1'b0);
        rd(24'h300, 8'h00);
        bus(1'b1, REG_ROW, 32'h340);
        run(OP_COPY_PROG, 1'b1);
        bus(1'b1, REG_ROW, 32'h301);
        run(OP_COPY_PROG, 1'b0);
        run(OP_PROG_CONF, 1'b0);
        complete_run();
    end
endmodule // ncs_nand_host_tb_top
